// ===== include/lcd_cmd_pkg.sv
// Purpose: shared constants for the lcd command interpreter and its host end
// Assumes: one clock, byte wide host bus, 16-bit display memory address
// Notes: command codes and reset values are the only place these numbers live
`default_nettype none
package lcd_cmd_pkg;
	// command codes written with cmd_data_select high
	localparam logic [7:0] CURSOR_FORM_CMD = 8'h5D;
	localparam logic [7:0] CURSOR_DIRECTION_CMD = 8'h4C; // 4C..4F
	localparam logic [7:0] LAYER_OVERLAY_CMD = 8'h5B;
	localparam logic [7:0] CHARGEN_BASE_CMD = 8'h5C;
	localparam logic [7:0] PIXEL_HSCROLL_CMD = 8'h5A;
	localparam logic [7:0] CURSOR_ADDR_WRITE_CMD = 8'h46;
	localparam logic [7:0] CURSOR_ADDR_READ_CMD = 8'h47;
	localparam logic [7:0] MEM_WRITE_CMD = 8'h42;
	localparam logic [7:0] MEM_READ_CMD = 8'h43;
	// direction codes in the two low command bits
	localparam logic [1:0] DIR_RIGHT = 2'h0;
	localparam logic [1:0] DIR_LEFT = 2'h1;
	localparam logic [1:0] DIR_UP = 2'h2;
	localparam logic [1:0] DIR_DOWN = 2'h3;
	// overlay parameter bit positions
	localparam int COMPOSE_LO_POS = 0;
	localparam int COMPOSE_HI_POS = 1;
	localparam int BLOCK1_MODE_POS = 2;
	localparam int BLOCK3_MODE_POS = 3;
	localparam int THREE_LAYER_POS = 4;
	// cursor form second parameter: shape in bit 7
	localparam int CURSOR_SHAPE_POS = 7;
	// reset values
	localparam logic [3:0] CURSOR_WIDTH_RST = 4'h7;
	localparam logic [3:0] CURSOR_HEIGHT_RST = 4'h7;
	localparam logic [15:0] POINTER_RST = 16'h0000;
	localparam logic [15:0] CHARGEN_RST = 16'h0000;
	// host end apb register offsets
	localparam logic [7:0] HOST_TXN_OFS = 8'h00;
	localparam logic [7:0] HOST_RDATA_OFS = 8'h04;
	// host transaction word fields
	localparam int TXN_SELECT_POS = 8;
	localparam int TXN_READ_POS = 9;
	// composition method codes
	typedef enum logic [1:0] {
		COMPOSE_OR = 2'b00,
		COMPOSE_XOR = 2'b01,
		COMPOSE_AND = 2'b10,
		COMPOSE_PRIO = 2'b11
	} compose_t;
endpackage
`default_nettype wire

// ===== include/lcd_bus_if.sv
// Purpose: byte wide bus between the host end and the lcd command device
// Assumes: both ends run on the same clock, strobes are one cycle pulses
// Notes: rd_ack answers every rd_stb exactly one cycle later
`default_nettype none
interface lcd_bus_if;
	logic cmd_data_select; // high: command / cursor data, low: param / status
	logic wr_stb; // one cycle write strobe
	logic rd_stb; // one cycle read strobe
	logic [7:0] wdata; // write byte
	logic [7:0] rdata; // read byte, valid with rd_ack
	logic rd_ack; // one cycle read answer
	modport dev (input cmd_data_select, wr_stb, rd_stb, wdata,
		output rdata, rd_ack);
	modport host (output cmd_data_select, wr_stb, rd_stb, wdata,
		input rdata, rd_ack);
endinterface
`default_nettype wire

// ===== hw/lcd_cmd_device.sv
// Purpose: command interpreter for cursor, layer and memory commands
// Assumes: memory returns mem_rdata one cycle after mem_re
// Notes: the host must space stream reads by two cycles or more
// Function
// - height code holds lines minus one
// - shape bit picks underscore or block
// - direction codes pick step size
// - direction step advances memory accesses
// - host adjusts address for wide characters
// - two bits pick layer combine method
// - one method covers whole layer
// - priority equals or without flashing
// - text first layer excludes third layer
// - mode bits for blocks one, three
// - host keeps both mode bits equal
// - overlay depth bit, cleared for text
// - chargen base stored from parameters
// - three bit whole screen pixel scroll
// - host sets row width before scroll
// - sixteen bit pointer addresses memory
// - pointer changes only by write, step
// - pointer read gives low then high
// - streamed writes advance pointer
// - streamed reads advance and prefetch
// - read data two steps ahead cursor
// - width field holds size minus one
// - select high means command write
//
// Our own choices: the address map and the APB slave port.
`default_nettype none
module lcd_cmd_device (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	lcd_bus_if.dev bus,
	input wire logic [7:0] address_pitch,
	input wire logic cursor_visible,
	input wire logic [7:0] mem_rdata,
	input wire logic [2:0] layer_pixel,
	input wire logic [2:0] layer_blank,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	output logic [15:0] display_cursor_pointer,
	output logic [3:0] cursor_width_field,
	output logic [3:0] cursor_height_field,
	output logic cursor_shape_select,
	output logic [1:0] compose_sel,
	output logic block1_mode_bit,
	output logic block3_mode_bit,
	output logic three_layer_select,
	output logic [15:0] chargen_base_addr,
	output logic [2:0] pixel_hscroll,
	output logic pixel_out
);
	////////////////////////////////////////////////////////////////////////
	// interpreter state
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_FORM = 4'b0001,
		ST_OVERLAY = 4'b0010,
		ST_CHARGEN = 4'b0011,
		ST_HSCROLL = 4'b0100,
		ST_PTR_WR = 4'b0101,
		ST_PTR_RD = 4'b0110,
		ST_STREAM_WR = 4'b0111,
		ST_STREAM_RD = 4'b1000
	} state_t;
	state_t state; // parameter collection or stream state
	state_t next_state;
	logic pidx; // second parameter byte pending
	logic [1:0] direction; // selected auto step
	logic [15:0] step; // signed step as 16-bit pattern
	logic [7:0] read_buf; // prefetched display byte
	logic fetch_pend; // memory answer arrives this cycle

	////////////////////////////////////////////////////////////////////////
	// bus decode
	// select high commands
	wire logic cmd_wr = ce & bus.wr_stb & bus.cmd_data_select;
	wire logic data_wr = ce & bus.wr_stb & ~bus.cmd_data_select;
	wire logic any_rd = ce & bus.rd_stb;
	wire logic data_rd = any_rd & bus.cmd_data_select;
	wire logic [7:0] cmd = bus.wdata;
	wire logic is_dir_cmd = cmd[7:2] == lcd_cmd_pkg::CURSOR_DIRECTION_CMD[7:2];
	wire logic [15:0] ptr_stepped = display_cursor_pointer + step;
	wire logic [15:0] ahead = cursor_visible ? {step[14:0], 1'b0} : 16'h0000;
	wire logic stream_rd = data_rd & (state == ST_STREAM_RD);
	wire logic [15:0] fetch_from = stream_rd ? ptr_stepped + ahead
		: display_cursor_pointer + ahead;

	// step for the current direction, pitch counted in bytes
	always_comb
	begin
		case (direction)
			lcd_cmd_pkg::DIR_RIGHT: step = 16'h0001;
			lcd_cmd_pkg::DIR_LEFT: step = 16'hFFFF;
			lcd_cmd_pkg::DIR_UP: step = 16'h0000 - {8'h00, address_pitch};
			lcd_cmd_pkg::DIR_DOWN: step = {8'h00, address_pitch};
			default: step = 16'h0001;
		endcase
	end

	// command decode picks the state that collects what follows
	always_comb
	begin
		next_state = state;
		if (cmd_wr)
		begin
			case (cmd)
				lcd_cmd_pkg::CURSOR_FORM_CMD: next_state = ST_FORM;
				lcd_cmd_pkg::LAYER_OVERLAY_CMD: next_state = ST_OVERLAY;
				lcd_cmd_pkg::CHARGEN_BASE_CMD: next_state = ST_CHARGEN;
				lcd_cmd_pkg::PIXEL_HSCROLL_CMD: next_state = ST_HSCROLL;
				lcd_cmd_pkg::CURSOR_ADDR_WRITE_CMD: next_state = ST_PTR_WR;
				lcd_cmd_pkg::CURSOR_ADDR_READ_CMD: next_state = ST_PTR_RD;
				lcd_cmd_pkg::MEM_WRITE_CMD: next_state = ST_STREAM_WR;
				lcd_cmd_pkg::MEM_READ_CMD: next_state = ST_STREAM_RD;
				default: next_state = ST_IDLE;
			endcase
		end
		else if (data_wr)
		begin
			case (state)
				ST_FORM, ST_CHARGEN, ST_PTR_WR:
					next_state = pidx ? ST_IDLE : state;
				ST_OVERLAY, ST_HSCROLL: next_state = ST_IDLE;
				default: next_state = state;
			endcase
		end
		else if (data_rd && state == ST_PTR_RD && pidx)
			next_state = ST_IDLE;
	end

	////////////////////////////////////////////////////////////////////////
	// state and parameter index
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			pidx <= 1'b0;
		end
		else if (cmd_wr)
		begin
			state <= next_state;
			pidx <= 1'b0;
		end
		else if (data_wr || data_rd)
		begin
			state <= next_state;
			pidx <= (next_state == state) ? ~pidx : 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration written by parameter bytes and by the direction commands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			direction <= lcd_cmd_pkg::DIR_RIGHT;
			cursor_width_field <= lcd_cmd_pkg::CURSOR_WIDTH_RST;
			cursor_height_field <= lcd_cmd_pkg::CURSOR_HEIGHT_RST;
			cursor_shape_select <= 1'b0;
			compose_sel <= 2'b00;
			block1_mode_bit <= 1'b0;
			block3_mode_bit <= 1'b0;
			three_layer_select <= 1'b0;
			chargen_base_addr <= lcd_cmd_pkg::CHARGEN_RST;
			pixel_hscroll <= 3'h0;
		end
		else if (cmd_wr && is_dir_cmd)
			direction <= cmd[1:0];
		else if (data_wr)
		begin
			case (state)
				ST_FORM:
				begin
					if (!pidx)
						cursor_width_field <= bus.wdata[3:0];
					else
					begin
						cursor_shape_select <=
							bus.wdata[lcd_cmd_pkg::CURSOR_SHAPE_POS];
						if (bus.wdata[3:0] != 4'h0)
							cursor_height_field <= bus.wdata[3:0];
					end
				end
				ST_OVERLAY:
				begin
					compose_sel <= {bus.wdata[lcd_cmd_pkg::COMPOSE_HI_POS],
						bus.wdata[lcd_cmd_pkg::COMPOSE_LO_POS]};
					block1_mode_bit <= bus.wdata[lcd_cmd_pkg::BLOCK1_MODE_POS];
					block3_mode_bit <= bus.wdata[lcd_cmd_pkg::BLOCK3_MODE_POS];
					three_layer_select <=
						bus.wdata[lcd_cmd_pkg::THREE_LAYER_POS];
				end
				ST_CHARGEN:
				begin
					if (!pidx)
						chargen_base_addr[7:0] <= bus.wdata;
					else
						chargen_base_addr[15:8] <= bus.wdata;
				end
				ST_HSCROLL: pixel_hscroll <= bus.wdata[2:0];
				default: pixel_hscroll <= pixel_hscroll;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cursor pointer and memory port
	// pointer drives memory accesses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			display_cursor_pointer <= lcd_cmd_pkg::POINTER_RST;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
			mem_re <= 1'b0;
		end
		else if (ce)
		begin
			mem_we <= 1'b0;
			mem_re <= 1'b0;
			if (data_wr && state == ST_PTR_WR)
			begin
				if (!pidx)
					display_cursor_pointer[7:0] <= bus.wdata;
				else
					display_cursor_pointer[15:8] <= bus.wdata;
			end
			else if (data_wr && state == ST_STREAM_WR)
			begin
				mem_addr <= display_cursor_pointer;
				mem_wdata <= bus.wdata;
				mem_we <= 1'b1;
				display_cursor_pointer <= ptr_stepped;
			end
			else if (stream_rd || (cmd_wr && cmd == lcd_cmd_pkg::MEM_READ_CMD))
			begin
				mem_addr <= fetch_from;
				mem_re <= 1'b1;
				if (stream_rd)
					display_cursor_pointer <= ptr_stepped;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read answers: prefetch buffer, pointer bytes, status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			read_buf <= 8'h00;
			fetch_pend <= 1'b0;
			bus.rdata <= 8'h00;
			bus.rd_ack <= 1'b0;
		end
		else if (ce)
		begin
			fetch_pend <= mem_re;
			if (fetch_pend)
				read_buf <= mem_rdata;
			bus.rd_ack <= any_rd;
			// a fetch landing in this cycle bypasses the buffer, so a
			// read two cycles after the previous stream read still gets fresh data
			if (stream_rd)
				bus.rdata <= fetch_pend ? mem_rdata : read_buf;
			else if (data_rd && state == ST_PTR_RD)
				bus.rdata <= pidx ? display_cursor_pointer[15:8]
					: display_cursor_pointer[7:0];
			else if (any_rd)
				bus.rdata <= 8'h00; // no status source in this block
		end
	end

	////////////////////////////////////////////////////////////////////////
	// layer composition, one method for the whole layer
	// layer wide method
	wire logic use_third = three_layer_select & block1_mode_bit;
	wire logic [2:0] vis = layer_pixel & ~layer_blank & {use_third, 2'b11};
	wire logic third_prio = use_third
		& (layer_blank[2] ? 1'b0 : layer_pixel[2]);
	// a blanked upper layer masks what lies beneath its own pixels
	wire logic second_prio = layer_blank[1] ? ~layer_pixel[1] & third_prio
		: layer_pixel[1] | third_prio;
	wire logic prio_px = layer_blank[0] ? ~layer_pixel[0] & second_prio
		: layer_pixel[0] | second_prio;
	logic next_pixel;

	always_comb
	begin
		case (compose_sel)
			lcd_cmd_pkg::COMPOSE_OR: next_pixel = |vis;
			lcd_cmd_pkg::COMPOSE_XOR: next_pixel = (vis[0] ^ vis[1]) | vis[2];
			lcd_cmd_pkg::COMPOSE_AND: next_pixel = (vis[0] & vis[1]) | vis[2];
			lcd_cmd_pkg::COMPOSE_PRIO: next_pixel = prio_px;
			default: next_pixel = |vis;
		endcase
	end

	// registered pixel keeps the output glitch free
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pixel_out <= 1'b0;
		else if (ce)
			pixel_out <= next_pixel;
	end
endmodule
`default_nettype wire

// ===== hw/lcd_host_end.sv
// Purpose: host end: apb registers turned into byte bus cycles
// Assumes: same clock as the device, rd_ack one cycle after rd_stb
// Notes: tracks overlay and form parameters to keep mode bits legal
`default_nettype none
module lcd_host_end (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	lcd_bus_if.host bus
);
	////////////////////////////////////////////////////////////////////////
	// apb decode
	wire logic access = ce & psel & penable & pready;
	wire logic hit_txn = paddr == lcd_cmd_pkg::HOST_TXN_OFS;
	wire logic hit_rd = paddr == lcd_cmd_pkg::HOST_RDATA_OFS;
	logic busy; // byte transfer in flight
	logic wait_ack; // read strobe sent, answer pending
	logic [7:0] last_cmd; // last command byte sent
	logic form_second; // next form parameter is the second one
	logic graphics; // first block is in graphics mode
	logic [7:0] rd_byte; // last byte read from the device
	wire logic start = access & pwrite & hit_txn & ~busy;
	wire logic is_sel = pwdata[lcd_cmd_pkg::TXN_SELECT_POS];
	wire logic is_rd = pwdata[lcd_cmd_pkg::TXN_READ_POS];
	wire logic [7:0] raw = pwdata[7:0];
	wire logic par_wr = ~is_sel & ~is_rd;
	wire logic overlay_par = par_wr
		& (last_cmd == lcd_cmd_pkg::LAYER_OVERLAY_CMD);
	wire logic form_par = par_wr & (last_cmd == lcd_cmd_pkg::CURSOR_FORM_CMD);
	logic [7:0] fixed;

	// parameter clean-up so the device never sees illegal mixes
	always_comb
	begin
		fixed = raw;
		if (overlay_par)
		begin
			fixed[lcd_cmd_pkg::BLOCK3_MODE_POS] =
				raw[lcd_cmd_pkg::BLOCK1_MODE_POS];
			if (!raw[lcd_cmd_pkg::BLOCK1_MODE_POS])
				fixed[lcd_cmd_pkg::THREE_LAYER_POS] = 1'b0;
		end
		if (form_par && form_second && graphics)
			fixed[lcd_cmd_pkg::CURSOR_SHAPE_POS] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer: one access cycle, registered data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready <= psel & ~penable & ~pready;
			pslverr <= psel & ~penable & ~hit_txn & ~hit_rd;
			if (psel && !penable)
				prdata <= hit_txn ? {31'h0000_0000, busy}
					: hit_rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// byte bus driver; a transaction written while busy is dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy <= 1'b0;
			wait_ack <= 1'b0;
			rd_byte <= 8'h00;
			bus.wr_stb <= 1'b0;
			bus.rd_stb <= 1'b0;
			bus.cmd_data_select <= 1'b0;
			bus.wdata <= 8'h00;
		end
		else if (ce)
		begin
			bus.wr_stb <= start & ~is_rd;
			bus.rd_stb <= start & is_rd;
			if (start)
			begin
				busy <= 1'b1;
				wait_ack <= is_rd;
				bus.cmd_data_select <= is_sel;
				bus.wdata <= fixed;
			end
			else if (wait_ack && bus.rd_ack)
			begin
				rd_byte <= bus.rdata;
				wait_ack <= 1'b0;
				busy <= 1'b0;
			end
			else if (!wait_ack && !bus.wr_stb && !bus.rd_stb)
				busy <= 1'b0;
		end
	end

	// mode tracking from what has been sent
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_cmd <= 8'h00;
			form_second <= 1'b0;
			graphics <= 1'b0;
		end
		else if (start && !is_rd)
		begin
			if (is_sel)
			begin
				last_cmd <= raw;
				form_second <= 1'b0;
			end
			else if (form_par)
				form_second <= ~form_second;
			if (overlay_par)
				graphics <= raw[lcd_cmd_pkg::BLOCK1_MODE_POS];
		end
	end
endmodule
`default_nettype wire

// ===== verif/lcd_bus_sva.sv
// Purpose: concurrent checks on the byte bus and the pointer
// Assumes: one clock, asynchronous active low reset
// Notes: watches only what the two design ends drive
`default_nettype none
module lcd_bus_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cmd_data_select,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] rdata,
	input wire logic rd_ack,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] display_cursor_pointer,
	input wire logic [3:0] cursor_height_field
);
	timeunit 1ns;
	timeprecision 1ps;
	// all checks share the single clock domain
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////
	chk_read_answer: assert property (
		rd_stb |=> rd_ack) else $error("no answer after read strobe");
	chk_ack_cause: assert property (
		rd_ack |-> $past(rd_stb)) else $error("answer without read");
	chk_status_zero: assert property (
		rd_stb && !cmd_data_select |=> rdata == 8'h00)
		else $error("status read not zero");
	chk_one_strobe: assert property (
		!(wr_stb && rd_stb)) else $error("read and write together");
	chk_height_legal: assert property (
		cursor_height_field != 4'h0) else $error("height code zero");
	chk_write_cause: assert property (
		mem_we |-> $past(wr_stb) && !$past(cmd_data_select))
		else $error("memory write without data byte");
	chk_write_address: assert property (
		mem_we |-> mem_addr == $past(display_cursor_pointer))
		else $error("memory write not at pointer");
	chk_pointer_cause: assert property (
		!$stable(display_cursor_pointer) |-> $past(wr_stb) || rd_ack)
		else $error("pointer moved without cause");
	// main scenarios reached
	cover property (rd_ack && cmd_data_select);
	cover property (mem_we);
	cover property (rd_stb && !cmd_data_select);
endmodule
`default_nettype wire

// ===== verif/tb_lcd_cursor_layer_memory_cmds.sv
// Purpose: drives both ends over apb and checks ports and memory
// Assumes: zero wait apb slave, memory answers one cycle after mem_re
// Notes: the memory model is preloaded with an address pattern
`default_nettype none
module tb_lcd_cursor_layer_memory_cmds;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] address_pitch = 8'h28;
	logic cursor_visible = 1'b0;
	logic [7:0] mem_rdata = 8'h00;
	logic [2:0] layer_pixel = 3'h0;
	logic [2:0] layer_blank = 3'h0; // flash-off phase per layer
	logic ce = 1'b1; // shared clock enable of both ends
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata;
	logic mem_we;
	logic mem_re;
	logic [15:0] ptr;
	logic [3:0] cursor_width_field;
	logic [3:0] cursor_height_field;
	logic cursor_shape_select;
	logic [1:0] compose_sel;
	logic block1_mode_bit;
	logic block3_mode_bit;
	logic three_layer_select;
	logic [15:0] chargen_base_addr;
	logic [2:0] pixel_hscroll;
	logic pixel_out;
	logic [7:0] ram [0:65535]; // display memory model
	logic [31:0] rd; // last apb read data
	logic err; // last apb error flag
	logic [15:0] stp; // expected pointer step
	logic exp_pix; // expected composed pixel
	int n_errors = 0;
	int check_count = 0;
	lcd_bus_if bus ();
	always #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////////
	lcd_cmd_device u_lcd_cmd_device (.pclk(pclk), .presetn(presetn),
		.ce(ce), .bus(bus), .address_pitch(address_pitch),
		.cursor_visible(cursor_visible), .mem_rdata(mem_rdata),
		.layer_pixel(layer_pixel), .layer_blank(layer_blank),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
		.mem_re(mem_re), .display_cursor_pointer(ptr),
		.cursor_width_field(cursor_width_field),
		.cursor_height_field(cursor_height_field),
		.cursor_shape_select(cursor_shape_select),
		.compose_sel(compose_sel), .block1_mode_bit(block1_mode_bit),
		.block3_mode_bit(block3_mode_bit),
		.three_layer_select(three_layer_select),
		.chargen_base_addr(chargen_base_addr),
		.pixel_hscroll(pixel_hscroll), .pixel_out(pixel_out));
	lcd_host_end u_lcd_host_end (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(bus));
	lcd_bus_sva u_lcd_bus_sva (.pclk(pclk), .presetn(presetn),
		.cmd_data_select(bus.cmd_data_select), .wr_stb(bus.wr_stb),
		.rd_stb(bus.rd_stb), .rdata(bus.rdata), .rd_ack(bus.rd_ack),
		.mem_we(mem_we), .mem_addr(mem_addr),
		.display_cursor_pointer(ptr),
		.cursor_height_field(cursor_height_field));
	// memory model: registered read keeps the one cycle latency
	always @(posedge pclk)
	begin
		if (mem_we)
			ram[mem_addr] <= mem_wdata;
		mem_rdata <= ram[mem_addr];
	end
	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	task end_of_test;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			n_errors++;
		end
	endtask
	// one apb transfer; held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n == 40)
		begin
			$display("mismatch pready expected 1 seen 0");
			n_errors++;
			end_of_test();
		end
		@(posedge pclk);
	endtask
	// poll busy; a txn sent while busy would be dropped
	task idle;
		int n;
		for (n = 0; n < 40; n++)
		begin
			apb(1'b0, lcd_cmd_pkg::HOST_TXN_OFS, 32'h0000_0000);
			if (rd[0] === 1'b0)
				break;
		end
		if (n == 40)
		begin
			$display("mismatch busy expected 0 seen 1");
			n_errors++;
			end_of_test();
		end
	endtask
	task send(input logic rdb, input logic sel, input logic [7:0] b);
		idle();
		apb(1'b1, lcd_cmd_pkg::HOST_TXN_OFS, {22'h0, rdb, sel, b});
		idle();
	endtask
	task cmd(input logic [7:0] b);
		send(1'b0, 1'b1, b);
	endtask
	task par(input logic [7:0] b);
		send(1'b0, 1'b0, b);
	endtask
	task rdbyte(input logic sel);
		send(1'b1, sel, 8'h00);
		apb(1'b0, lcd_cmd_pkg::HOST_RDATA_OFS, 32'h0000_0000);
	endtask
	task set_ptr(input logic [15:0] a);
		cmd(lcd_cmd_pkg::CURSOR_ADDR_WRITE_CMD);
		par(a[7:0]);
		par(a[15:8]);
	endtask
	////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		for (int i = 0; i < 65536; i++)
			ram[i] = pat(16'(i));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("width", 32'h7, cursor_width_field);
		check("height", 32'h7, cursor_height_field);
		check("pointer", 32'h0, ptr);
		apb(1'b0, 8'h08, 32'h0000_0000);
		check("slverr", 32'h1, err);
		check("unmapped", 32'h0, rd);
		set_ptr(16'h1234);
		check("pointer", 32'h1234, ptr);
		cmd(lcd_cmd_pkg::CURSOR_ADDR_READ_CMD);
		rdbyte(1'b1);
		check("ptr low", 32'h34, rd);
		rdbyte(1'b1);
		check("ptr high", 32'h12, rd);
		rdbyte(1'b0);
		check("status", 32'h0, rd);
		// every direction code, two streamed writes each
		for (int d = 0; d < 4; d++)
		begin
			stp = (d == 0) ? 16'h0001 : (d == 1) ? 16'hFFFF :
				(d == 2) ? -{8'h00, address_pitch} : {8'h00, address_pitch};
			set_ptr(16'h1000);
			cmd(lcd_cmd_pkg::CURSOR_DIRECTION_CMD | 8'(d));
			cmd(lcd_cmd_pkg::MEM_WRITE_CMD);
			par(8'hA0 + 8'(d));
			par(8'hB0 + 8'(d));
			check("first", 32'hA0 + d, ram[16'h1000]);
			check("second", 32'hB0 + d, ram[16'h1000 + stp]);
			check("ptr step", 16'(16'h1000 + stp + stp), ptr);
		end
		set_ptr(16'hFFFF);
		cmd(lcd_cmd_pkg::CURSOR_DIRECTION_CMD);
		cmd(lcd_cmd_pkg::MEM_WRITE_CMD);
		par(8'hC3);
		check("top", 32'hC3, ram[16'hFFFF]);
		check("wrap", 32'h0, ptr);
		set_ptr(16'h2000);
		cmd(lcd_cmd_pkg::MEM_READ_CMD);
		rdbyte(1'b1);
		check("read0", pat(16'h2000), rd);
		rdbyte(1'b1);
		check("read1", pat(16'h2001), rd);
		check("read ptr", 32'h2002, ptr);
		cursor_visible <= 1'b1;
		set_ptr(16'h3000);
		cmd(lcd_cmd_pkg::MEM_READ_CMD);
		rdbyte(1'b1);
		check("ahead", pat(16'h3002), rd);
		check("ahead ptr", 32'h3001, ptr);
		cursor_visible <= 1'b0;
		cmd(lcd_cmd_pkg::CURSOR_FORM_CMD);
		par(8'h03);
		par(8'h85);
		check("width", 32'h3, cursor_width_field);
		check("shape", 32'h1, cursor_shape_select);
		check("height", 32'h5, cursor_height_field);
		cmd(lcd_cmd_pkg::CURSOR_FORM_CMD);
		par(8'h02);
		par(8'h00);
		check("zero kept", 32'h5, cursor_height_field);
		check("shape", 32'h0, cursor_shape_select);
		// every compose code against every pixel pattern
		for (int c = 0; c < 4; c++)
		begin
			cmd(lcd_cmd_pkg::LAYER_OVERLAY_CMD);
			par(8'h1C | 8'(c));
			check("compose", c, compose_sel);
			check("three", 32'h1, three_layer_select);
			for (int p = 0; p < 8; p++)
			begin
				layer_pixel <= 3'(p);
				repeat (2) @(posedge pclk);
				exp_pix = (c == 1) ? (layer_pixel[0] ^ layer_pixel[1]) :
					(c == 2) ? (layer_pixel[0] & layer_pixel[1]) :
					(layer_pixel[0] | layer_pixel[1]);
				exp_pix = exp_pix | layer_pixel[2];
				check("pixel", exp_pix, pixel_out);
			end
		end
		// priority: a blanked top layer hides what lies under it
		layer_blank <= 3'h1;
		layer_pixel <= 3'h3;
		repeat (2) @(posedge pclk);
		check("blank prio", 32'h0, pixel_out);
		// a low clock enable holds the composed pixel
		ce <= 1'b0;
		layer_blank <= 3'h0;
		repeat (2) @(posedge pclk);
		check("frozen", 32'h0, pixel_out);
		ce <= 1'b1;
		repeat (2) @(posedge pclk);
		check("pixel", 32'h1, pixel_out);
		cmd(lcd_cmd_pkg::LAYER_OVERLAY_CMD);
		par(8'h05);
		check("block3", 32'h1, block3_mode_bit);
		cmd(lcd_cmd_pkg::LAYER_OVERLAY_CMD);
		par(8'h10);
		check("block1", 32'h0, block1_mode_bit);
		check("depth", 32'h0, three_layer_select);
		cmd(lcd_cmd_pkg::LAYER_OVERLAY_CMD);
		par(8'h0C);
		cmd(lcd_cmd_pkg::CURSOR_FORM_CMD);
		par(8'h02);
		par(8'h05);
		check("block cursor", 32'h1, cursor_shape_select);
		cmd(lcd_cmd_pkg::CHARGEN_BASE_CMD);
		par(8'h78);
		par(8'h56);
		check("chargen", 32'h5678, chargen_base_addr);
		set_ptr(16'h4321);
		cmd(lcd_cmd_pkg::PIXEL_HSCROLL_CMD);
		par(8'h07);
		check("hscroll", 32'h7, pixel_hscroll);
		cmd(lcd_cmd_pkg::PIXEL_HSCROLL_CMD);
		par(8'hFD);
		check("hscroll", 32'h5, pixel_hscroll);
		check("ptr kept", 32'h4321, ptr);
		end_of_test();
	end
endmodule
`default_nettype wire
